//--- design/ewp_pkg.sv
// Constants for the write-protection and status logic of the serial memory
// Notes on behaviour
// - Internal array or status write starts only while the latch is set.
// - Set-enable command sets the latch; clear-enable command clears it.
// - Latch clears at reset and after clear-enable, status-write or array-write.
// - Latch is held clear while the write-protect input is low.
// - Status-read returns the status byte at any time, even while busy.
// - Status byte: bit3 upper protect, bit2 lower protect, bit1 latch, bit0 busy.
// - Busy flag reads 1 during an internal write, 0 otherwise.
// - Latch flag mirrors the latch; 1 permits writes, 0 forbids them.
// - Set and clear-enable update the latch regardless of status protection.
// - Protect bits change only by status-write and survive reset.
// - Protect map: 00 none, 01 180-1FF, 10 100-1FF, 11 000-1FF.
// - Internal write starts only when select rises on a byte boundary.
// - Array access during an internal write is ignored; programming continues.
// - After reset: standby, latch clear, output released until a status-read opcode has been shifted in.
// - Writes blocked when protect pin low or latch 0; protected blocks stay locked.
// - Set-enable opcode is 0x06, MSB first.
// - Clear-enable opcode is 0x04, MSB first.
// - Status-read opcode 0x05, status-write opcode 0x01.
// - Latch is set only at the select rising edge after eight opcode bits.
`default_nettype none
package ewp_pkg;
    //------------------------------------------------------------------
    // Opcodes
    //------------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH  = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STAT_READ  = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_READ_MASK  = 8'hF7;
    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_WRITE      = 8'h02;
    //------------------------------------------------------------------
    // Status byte layout
    //------------------------------------------------------------------
    localparam int BIT_BUSY  = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 3;
    localparam logic [1:0] BP_RESET = 2'h0;
    //------------------------------------------------------------------
    // Protection map
    //------------------------------------------------------------------
    localparam logic [8:0] QUARTER_BASE = 9'h180;
    localparam logic [8:0] HALF_BASE    = 9'h100;
    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int CLK_HZ        = 25000000;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES  = (CLK_HZ / 1000000) * WRITE_TIME_US;
    localparam int BIT_CNT_W     = 6;
endpackage : ewp_pkg
`default_nettype wire

//--- design/ewp_top.sv
// Write-protection and status logic behind the serial pins
`timescale 1ns/1ps
`default_nettype none
module ewp_top #(
    parameter int WRITE_CYCLES = ewp_pkg::WRITE_CYCLES
) (
    input  wire logic SYS_CLK_I,
    input  wire logic RST_I,
    input  wire logic CS_N_I,
    input  wire logic SCK_I,
    input  wire logic SI_I,
    input  wire logic WP_N_I,
    output logic      SO_O,
    output logic      SO_OE_N_O,
    output logic      BUSY_O,
    output logic      ARRAY_WR_O,
    output logic [8:0] ARRAY_ADDR_O
);
    //------------------------------------------------------------------
    // Synchronisers
    //------------------------------------------------------------------
    logic [1:0] cs_s, sck_s, si_s, wp_s;
    logic       sck_d, cs_d;
    always_ff @(posedge SYS_CLK_I) begin
        cs_s  <= {cs_s[0], CS_N_I};
        sck_s <= {sck_s[0], SCK_I};
        si_s  <= {si_s[0], SI_I};
        wp_s  <= {wp_s[0], WP_N_I};
        sck_d <= sck_s[1];
        cs_d  <= cs_s[1];
    end
    wire sel      = !cs_s[1];
    wire sck_rise = sel && sck_s[1] && !sck_d;
    wire sck_fall = sel && !sck_s[1] && sck_d;
    wire cs_rise  = cs_s[1] && !cs_d;
    wire wp_ok    = wp_s[1];

    //------------------------------------------------------------------
    // Serial shift-in
    //------------------------------------------------------------------
    localparam int BIT_W = ewp_pkg::BIT_CNT_W;
    logic [BIT_W-1:0] bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  opcode;
    logic [8:0]  addr;
    logic [7:0]  wdata;
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || !sel) begin
            bit_cnt <= '0;
            shreg   <= 8'h00;
        end else if (sck_rise) begin
            shreg <= {shreg[6:0], si_s[1]};
            if (bit_cnt != {BIT_W{1'b1}})
                bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == 6'h07)
                opcode <= {shreg[6:0], si_s[1]};
            if (bit_cnt == 6'h0F)
                addr <= {opcode[3], shreg[6:0], si_s[1]};
            if (bit_cnt[2:0] == 3'h7)
                wdata <= {shreg[6:0], si_s[1]};
        end
    end

    //------------------------------------------------------------------
    // Protection map and command decode
    //------------------------------------------------------------------
    logic       latch;
    logic [1:0] bp;
    logic       busy;
    function automatic logic is_protected(input logic [1:0] b,
                                          input logic [8:0] a);
        case (b)
            2'h0:    is_protected = 1'b0;
            2'h1:    is_protected = a >= ewp_pkg::QUARTER_BASE;
            2'h2:    is_protected = a >= ewp_pkg::HALF_BASE;
            default: is_protected = 1'b1;
        endcase
    endfunction
    // select must rise on a byte boundary
    wire byte_edge = cs_rise && bit_cnt[2:0] == 3'h0;
    wire op_full   = byte_edge && bit_cnt == 6'h08;
    // nothing but status read while busy
    wire do_set  = op_full && opcode == ewp_pkg::OP_SET_LATCH && !busy;
    wire do_clr  = op_full && opcode == ewp_pkg::OP_CLR_LATCH && !busy;
    // writes need latch set and protect pin high
    wire allow   = latch && wp_ok && !busy;
    wire do_swr  = byte_edge && bit_cnt == 6'h10 && allow &&
                   opcode == ewp_pkg::OP_STAT_WRITE;
    wire do_awr  = byte_edge && bit_cnt >= 6'h18 && allow &&
                   (opcode & ewp_pkg::OP_READ_MASK) == ewp_pkg::OP_WRITE &&
                   !is_protected(bp, addr);

    //------------------------------------------------------------------
    // Write enable latch
    //------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        // clear on reset or protect pin low
        if (RST_I || !wp_ok)
            latch <= 1'b0;
        // set at select rise after full opcode
        else if (do_set)
            latch <= 1'b1;
        else if (do_clr || do_swr || do_awr)
            latch <= 1'b0;
    end

    //------------------------------------------------------------------
    // Protect bits, held across reset
    //------------------------------------------------------------------
    // Power-up value; the protect bits never see the reset input
    logic bp_init = 1'b0;
    always_ff @(posedge SYS_CLK_I) begin
        if (!bp_init) begin
            bp      <= ewp_pkg::BP_RESET;
            bp_init <= 1'b1;
        end else if (do_swr) begin
            bp <= {wdata[ewp_pkg::BIT_BP_HI], wdata[ewp_pkg::BIT_BP_LO]};
        end
    end

    //------------------------------------------------------------------
    // Internal write timer
    //------------------------------------------------------------------
    logic [22:0] wcnt;
    always_ff @(posedge SYS_CLK_I) begin
        // busy from select rise until timer ends
        if (RST_I) begin
            busy <= 1'b0;
            wcnt <= '0;
        end else if (do_swr || do_awr) begin
            busy <= 1'b1;
            wcnt <= 23'(WRITE_CYCLES - 1);
        end else if (busy) begin
            if (wcnt == '0)
                busy <= 1'b0;
            else
                wcnt <= wcnt - 23'h1;
        end
    end

    //------------------------------------------------------------------
    // Status output and pins
    //------------------------------------------------------------------
    // status byte layout
    wire [7:0] status = {4'h0, bp, latch, busy};
    logic [7:0] oshift;
    logic       reading;
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || !sel) begin
            reading   <= 1'b0;
            SO_OE_N_O <= 1'b1;
            SO_O      <= 1'b0;
            oshift    <= 8'h00;
        end else if (sck_fall && bit_cnt[2:0] == 3'h0 && bit_cnt != 6'h00 &&
                     (reading || opcode == ewp_pkg::OP_STAT_READ)) begin
            // status read allowed even while busy
            reading   <= 1'b1;
            SO_OE_N_O <= 1'b0;
            SO_O      <= status[7];
            oshift    <= {status[6:0], 1'b0};
        end else if (sck_fall && reading) begin
            SO_O   <= oshift[7];
            oshift <= {oshift[6:0], 1'b0};
        end
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            BUSY_O       <= 1'b0;
            ARRAY_WR_O   <= 1'b0;
            ARRAY_ADDR_O <= 9'h000;
        end else begin
            BUSY_O       <= busy;
            ARRAY_WR_O   <= do_awr;
            ARRAY_ADDR_O <= addr;
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);
    sequence set_cmd_s;
        do_set && wp_ok;
    endsequence
    latch_set_a: assert property (set_cmd_s |=> latch)
        else $error("latch not set");
    latch_clr_a: assert property (do_clr |=> !latch)
        else $error("latch not cleared");
    wp_hold_a: assert property (!wp_ok |=> !latch)
        else $error("latch set while protect low");
    write_gate_a: assert property ((do_swr || do_awr) |-> latch && wp_ok)
        else $error("write without latch");
    busy_start_a: assert property (
        (do_swr || do_awr) |=> busy ##1 BUSY_O)
        else $error("busy not raised");
    prot_map_a: assert property (
        do_awr |-> !(bp == 2'h3) && !(bp != 2'h0 && addr == 9'h1FF))
        else $error("protected address written");
    no_restart_a: assert property (
        busy && !$past(do_swr || do_awr) |-> !do_awr)
        else $error("write accepted while busy");
    upper_zero_a: assert property (
        status[7:4] == 4'h0 && status[1] == latch)
        else $error("status layout wrong");
    so_idle_a: assert property ($rose(cs_s[1]) |=> SO_OE_N_O)
        else $error("output not released");
    wr_busy_a: assert property (BUSY_O |-> !ARRAY_WR_O)
        else $error("array write while busy");
    bp_hold_a: assert property (!do_swr |=> $stable(bp))
        else $error("protect bits changed");
    latch_rise_a: assert property ($rose(latch) |-> $past(cs_rise))
        else $error("latch set away from select rise");
endmodule : ewp_top
`default_nettype wire

//--- bench/ewp_host.sv
// SPI host model that frames commands toward the protection block
`timescale 1ns/1ps
`default_nettype none
module ewp_host (
    input  wire logic clk_i,
    input  wire logic so_i,
    output var logic  cs_n_o,
    output var logic  sck_o,
    output var logic  si_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // select rises after the last bit
    task automatic xfer(input int nb, input logic [31:0] d,
                        output logic [31:0] r);
        r = '0;
        @(negedge clk_i) cs_n_o = 1'b0;
        for (int i = 0; i < nb; i++) begin
            si_o = d[31 - i];
            repeat (4) @(negedge clk_i);
            sck_o = 1'b1;
            repeat (2) @(negedge clk_i);
            r = {r[30:0], so_i};
            repeat (2) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // Idle data line must not keep the last bit
        si_o = ~si_o;
        repeat (6) @(negedge clk_i);
    endtask
endmodule // ewp_host
`default_nettype wire

//--- bench/tb_ewp_top.sv
// Self-checking bench for the write-protection and status logic
`timescale 1ns/1ps
`default_nettype none
module tb_ewp_top;
    logic clk, rst, cs_n, sck, si, wp_n, so, oe_n, busy, awr, ok;
    logic [8:0]  aaddr, a;
    logic [31:0] r;
    logic [7:0]  s;
    logic [1:0]  bp;
    int fail_count = 0;
    int n_tests = 0;
    int wr_cnt = 0;
    int n;
    ewp_top #(.WRITE_CYCLES(400)) u_ewp_top (
        .SYS_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck),
        .SI_I(si), .WP_N_I(wp_n), .SO_O(so), .SO_OE_N_O(oe_n),
        .BUSY_O(busy), .ARRAY_WR_O(awr), .ARRAY_ADDR_O(aaddr));
    ewp_host u_ewp_host (.clk_i(clk), .so_i(so), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (awr === 1'b1) wr_cnt++;
    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmd(input int nb, input logic [31:0] d);
        u_ewp_host.xfer(nb, d, r);
    endtask
    task automatic rd();
        cmd(16, {ewp_pkg::OP_STAT_READ, 24'h0});
        s = r[7:0];
    endtask
    task automatic idle();
        for (int i = 0; i < 600 && busy === 1'b1; i++) @(negedge clk);
        chk({7'h0, busy}, 8'h00);
    endtask
    task automatic setbp(input logic [1:0] b);
        wp_n = 1'b1;
        cmd(8, {ewp_pkg::OP_SET_LATCH, 24'h0});
        cmd(16, {ewp_pkg::OP_STAT_WRITE, 4'h0, b, 2'h0, 16'h0});
        rd();
        chk(s & 8'hFD, {4'h0, b, 2'h1});
        idle();
        rd();
        chk(s, {4'h0, b, 2'h0});
    endtask
    function automatic logic prot(input logic [1:0] b, input logic [8:0] x);
        case (b)
            2'h0: return 1'b0;
            2'h1: return x >= 9'h180;
            2'h2: return x >= 9'h100;
            default: return 1'b1;
        endcase
    endfunction
    initial begin
        #3000000;
        fail_count++;
        stop_test();
    end
    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        r = $urandom(32'h0F4C);
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h0, oe_n}, 8'h01);
        rd();
        chk(s, 8'h00);
        cmd(8, {ewp_pkg::OP_SET_LATCH, 24'h0});
        rd();
        chk(s, 8'h02);
        cmd(8, {ewp_pkg::OP_CLR_LATCH, 24'h0});
        rd();
        chk(s, 8'h00);
        cmd(7, {ewp_pkg::OP_SET_LATCH, 24'h0});
        rd();
        chk(s, 8'h00);
        wp_n = 1'b0;
        cmd(8, {ewp_pkg::OP_SET_LATCH, 24'h0});
        rd();
        chk(s, 8'h00);
        wp_n = 1'b1;
        cmd(16, {ewp_pkg::OP_STAT_WRITE, 8'h0C, 16'h0});
        rd();
        chk(s, 8'h00);
        cmd(8, {ewp_pkg::OP_SET_LATCH, 24'h0});
        cmd(15, {ewp_pkg::OP_STAT_WRITE, 8'h0C, 16'h0});
        rd();
        chk(s, 8'h02);
        for (int i = 0; i < 4; i++) begin
            bp = i[1:0];
            setbp(bp);
            for (int j = 0; j < 4; j++) begin
                a = (j == 0) ? 9'h17F : (j == 1) ? 9'h180 :
                    (j == 2) ? 9'h0FF : 9'($urandom);
                wp_n = 1'b1;
                cmd(8, {ewp_pkg::OP_SET_LATCH, 24'h0});
                wp_n = 1'($urandom_range(0, 3) != 0);
                ok = wp_n & ~prot(bp, a);
                n = wr_cnt;
                cmd(24, {4'h0, a[8], 3'h2, a[7:0], 8'($urandom), 8'h0});
                chk(8'(wr_cnt - n), {7'h0, ok});
                if (ok) begin
                    chk({7'h0, busy}, 8'h01);
                    chk(aaddr[7:0], a[7:0]);
                    chk({7'h0, aaddr[8]}, {7'h0, a[8]});
                    cmd(24, {4'h0, a[8], 3'h2, a[7:0], 16'h5A00});
                    chk(8'(wr_cnt - n), 8'h01);
                    idle();
                end
                rd();
                chk(s, {4'h0, bp, wp_n & ~ok, 1'b0});
            end
        end
        setbp(2'h2);
        cmd(8, {ewp_pkg::OP_SET_LATCH, 24'h0});
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        cmd(16, {ewp_pkg::OP_STAT_WRITE, 8'h00, 16'h0});
        rd();
        chk(s, 8'h08);
        stop_test();
    end
endmodule // tb_ewp_top
`default_nettype wire
